// [design/aqcd_byte_store.sv]
/*
 Four configuration bytes with defaults at reset.
 Assumes synchronous active-high reset on the configuration clock.
*/
`timescale 1ns/1ps
`default_nettype none
module aqcd_byte_store
   import aqcd_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Write port
   aqcd_cfg_if.store cfg
);
   genvar g;
   generate
      for (g = 0; g < AQCD_NUM_BYTES; g++) begin : g_byte
         localparam logic [7:0] RST_VAL =
            (g == AQCD_OFS_GATE) ? AQCD_RST_GATE : AQCD_RST_INPUT;
         logic [7:0] byte_reg;
         wire hit = cfg.wr_en && (cfg.wr_addr == 2'(g));
         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               byte_reg <= RST_VAL; // [R12]
            end else if (hit) begin
               byte_reg <= cfg.wr_data; // [R13]
            end
         end
         assign cfg.byte_q[g] = byte_reg;
      end
   endgenerate
endmodule
`default_nettype wire

// [design/aqcd_top.sv]
/*
 Analog quad configuration decoder: stores the four bytes written over
 the analog configuration port and drives analog control lines.
 Assumes the port inputs are on i_clk; gate_driver_on is a pin.
*/
`timescale 1ns/1ps
`default_nettype none
module aqcd_top
   import aqcd_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Analog configuration port
   input wire logic i_cfg_wr_en,
   input wire logic [1:0] i_cfg_addr,
   input wire logic [7:0] i_cfg_wdata,
   output logic [7:0] o_cfg_rdata,
   // Gate driver enable pin
   input wire logic i_gate_driver_on,
   // Voltage pad
   output logic [2:0] o_voltage_pad_scale,
   output logic [3:0] o_voltage_pad_adc_src,
   output logic o_voltage_pad_direct_sw,
   output logic o_voltage_pad_negative,
   output logic o_voltage_pad_opamp_on,
   output logic o_current_monitor_sw,
   // Current pad
   output logic [2:0] o_current_pad_scale,
   output logic [3:0] o_current_pad_adc_src,
   output logic o_current_pad_direct_sw,
   output logic o_current_pad_negative,
   output logic o_current_pad_opamp_on,
   // Temperature pad
   output logic [2:0] o_temperature_pad_scale,
   output logic [3:0] o_temperature_pad_adc_src,
   output logic o_temperature_pad_direct_sw,
   output logic o_temperature_pad_negative,
   output logic o_temperature_pad_opamp_on,
   output logic o_temperature_pad_cfg_err,
   // Gate pad
   output logic [1:0] o_gate_pad_current_sel,
   output logic o_gate_pad_negative,
   output logic [3:0] o_gate_pad_mode,
   output logic o_temp_monitor_power_ctl
);
   aqcd_cfg_if cfg ();

   aqcd_byte_store u_store (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .cfg(cfg)
   );

   assign cfg.wr_en = i_cfg_wr_en;
   assign cfg.wr_addr = i_cfg_addr;
   assign cfg.wr_data = i_cfg_wdata;

   // Gate driver enable comes from a pin
   logic gate_driver_on_meta_reg;
   logic gate_driver_on_sync_reg;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         gate_driver_on_meta_reg <= 1'h0;
         gate_driver_on_sync_reg <= 1'h0;
      end else begin
         gate_driver_on_meta_reg <= i_gate_driver_on;
         gate_driver_on_sync_reg <= gate_driver_on_meta_reg;
      end
   end

   function automatic aqcd_adc_src_e mux_dec(input logic [1:0] sel);
      aqcd_adc_src_e r;
      case (sel)
         AQCD_MUX_PRESCALER: r = AQCD_ADC_PRESCALER;
         AQCD_MUX_DIRECT: r = AQCD_ADC_DIRECT;
         AQCD_MUX_MONITOR: r = AQCD_ADC_MONITOR;
         default: r = AQCD_ADC_NONE;
      endcase
      return r;
   endfunction

   wire [7:0] vb = cfg.byte_q[AQCD_OFS_VOLTAGE];
   wire [7:0] cb = cfg.byte_q[AQCD_OFS_CURRENT];
   wire [7:0] gb = cfg.byte_q[AQCD_OFS_GATE];
   wire [7:0] tb = cfg.byte_q[AQCD_OFS_TEMP];

   // Decoded next values
   wire [3:0] v_src_next = mux_dec(vb[AQCD_POS_MUX_LO +: 2]); // [R1]
   wire [3:0] c_src_next = mux_dec(cb[AQCD_POS_MUX_LO +: 2]); // [R1]
   wire [3:0] t_src_next = mux_dec(tb[AQCD_POS_MUX_LO +: 2]); // [R1]
   wire [2:0] t_scale = tb[AQCD_POS_SCALE_LO +: 3];
   // Only two scaling codes and positive polarity suit this pad
   wire t_err_next = ((t_scale != AQCD_TSCALE_16V) &&
      (t_scale != AQCD_TSCALE_4V)) || tb[AQCD_POS_POLARITY]; // [R11] [R4]

   aqcd_gate_e gate_mode_next;
   always_comb begin
      gate_mode_next = AQCD_GATE_OFF;
      case ({gb[AQCD_POS_HIGH_DRIVE], gate_driver_on_sync_reg})
         2'h0: gate_mode_next = AQCD_GATE_OFF; // [R9]
         2'h1: gate_mode_next = AQCD_GATE_LOW; // [R9]
         2'h2: gate_mode_next = AQCD_GATE_OFF; // [R9]
         2'h3: gate_mode_next = AQCD_GATE_HIGH; // [R9]
         default: gate_mode_next = AQCD_GATE_BAD;
      endcase
   end

   wire [7:0] rdata_next = cfg.byte_q[i_cfg_addr];

   // Field slices feeding the control registers
   wire [2:0] v_scale_next = vb[AQCD_POS_SCALE_LO +: 3];
   wire v_direct_next = vb[AQCD_POS_DIRECT];
   wire v_neg_next = vb[AQCD_POS_POLARITY];
   wire v_opamp_next = vb[AQCD_POS_OPAMP];
   wire v_curmon_next = vb[AQCD_POS_CURMON];
   wire [2:0] c_scale_next = cb[AQCD_POS_SCALE_LO +: 3];
   wire c_direct_next = cb[AQCD_POS_DIRECT];
   wire c_neg_next = cb[AQCD_POS_POLARITY];
   wire c_opamp_next = cb[AQCD_POS_OPAMP];
   wire t_direct_next = tb[AQCD_POS_DIRECT];
   wire t_neg_next = tb[AQCD_POS_POLARITY];
   wire t_opamp_next = tb[AQCD_POS_OPAMP];
   wire [1:0] g_cur_next = gb[AQCD_POS_DRIVE_LO +: 2];
   wire g_neg_next = gb[AQCD_POS_POLARITY];
   wire g_tmon_next = gb[AQCD_POS_TMON];

   // Voltage pad control lines
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_voltage_pad_scale <= AQCD_RST_INPUT[2:0];
      end else begin
         o_voltage_pad_scale <= v_scale_next; // [R11]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_voltage_pad_adc_src <= AQCD_ADC_PRESCALER;
      end else begin
         o_voltage_pad_adc_src <= v_src_next; // [R1]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_voltage_pad_direct_sw <= 1'h0;
      end else begin
         o_voltage_pad_direct_sw <= v_direct_next; // [R2]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_voltage_pad_negative <= 1'h0;
      end else begin
         o_voltage_pad_negative <= v_neg_next; // [R3]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_voltage_pad_opamp_on <= 1'h0;
      end else begin
         o_voltage_pad_opamp_on <= v_opamp_next; // [R5]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_current_monitor_sw <= 1'h0;
      end else begin
         o_current_monitor_sw <= v_curmon_next; // [R6]
      end
   end

   // Current pad control lines
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_current_pad_scale <= AQCD_RST_INPUT[2:0];
      end else begin
         o_current_pad_scale <= c_scale_next; // [R11]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_current_pad_adc_src <= AQCD_ADC_PRESCALER;
      end else begin
         o_current_pad_adc_src <= c_src_next; // [R1]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_current_pad_direct_sw <= 1'h0;
      end else begin
         o_current_pad_direct_sw <= c_direct_next; // [R2]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_current_pad_negative <= 1'h0;
      end else begin
         o_current_pad_negative <= c_neg_next; // [R3]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_current_pad_opamp_on <= 1'h0;
      end else begin
         o_current_pad_opamp_on <= c_opamp_next; // [R5]
      end
   end

   // Temperature pad control lines
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_temperature_pad_scale <= AQCD_RST_INPUT[2:0];
      end else begin
         o_temperature_pad_scale <= t_scale; // [R11]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_temperature_pad_adc_src <= AQCD_ADC_PRESCALER;
      end else begin
         o_temperature_pad_adc_src <= t_src_next; // [R1]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_temperature_pad_direct_sw <= 1'h0;
      end else begin
         o_temperature_pad_direct_sw <= t_direct_next; // [R2]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_temperature_pad_negative <= 1'h0;
      end else begin
         o_temperature_pad_negative <= t_neg_next; // [R3]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_temperature_pad_opamp_on <= 1'h0;
      end else begin
         o_temperature_pad_opamp_on <= t_opamp_next; // [R5]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_temperature_pad_cfg_err <= 1'h0;
      end else begin
         o_temperature_pad_cfg_err <= t_err_next; // [R11]
      end
   end

   // Gate pad control lines
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_gate_pad_current_sel <= AQCD_RST_GATE[3:2];
      end else begin
         o_gate_pad_current_sel <= g_cur_next; // [R7]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_gate_pad_negative <= 1'h0;
      end else begin
         o_gate_pad_negative <= g_neg_next; // [R8]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_gate_pad_mode <= AQCD_GATE_OFF;
      end else begin
         o_gate_pad_mode <= gate_mode_next; // [R9]
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_temp_monitor_power_ctl <= 1'h0;
      end else begin
         o_temp_monitor_power_ctl <= g_tmon_next; // [R10]
      end
   end

   // Read back of the addressed byte
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_cfg_rdata <= 8'h00;
      end else begin
         o_cfg_rdata <= rdata_next; // [R13]
      end
   end
endmodule
`default_nettype wire

// [inc/aqcd_cfg_if.sv]
/*
 Write port between the decoder top and its byte store.
 Assumes a single clock shared by both sides.
*/
`timescale 1ns/1ps
`default_nettype none
interface aqcd_cfg_if;
   logic wr_en;
   logic [1:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] byte_q [4];
   modport store (input wr_en, wr_addr, wr_data, output byte_q);
   modport ctrl (output wr_en, wr_addr, wr_data, input byte_q);
endinterface
`default_nettype wire

// [inc/aqcd_pkg.sv]
/*
 Constants and types for the analog quad configuration decoder.
 Assumes the configuration port writes one byte per enabled clock edge.
*/
// How it works
// R1 - Mux field routes prescaler, direct, or monitor
// R2 - Bit 5 closes direct input switch
// R3 - Bit 6 selects input pad polarity
// R4 - Configurer keeps temperature pad bit 6 zero
// R5 - Bit 7 powers prescaler op amp
// R6 - Voltage byte bit 4 enables current monitor
// R7 - Gate bits 3:2 pick low drive current
// R8 - Gate bit 6 sets driver polarity
// R9 - Driver on plus bit 7 picks drive
// R10 - Gate bit 0 powers temperature monitor
// R11 - Bits 2:0 pick prescaler scaling factor
// R12 - Bytes load defaults at reset
// R13 - Bytes hold until written again
package aqcd_pkg;
   localparam logic [1:0] AQCD_OFS_VOLTAGE = 2'h0;
   localparam logic [1:0] AQCD_OFS_CURRENT = 2'h1;
   localparam logic [1:0] AQCD_OFS_GATE = 2'h2;
   localparam logic [1:0] AQCD_OFS_TEMP = 2'h3;
   localparam int AQCD_NUM_BYTES = 4;
   // Default: 16 V range, prescaler, switches off, positive, powered down
   localparam logic [7:0] AQCD_RST_INPUT = 8'h00;
   // Default: monitor off, lowest current, positive, low drive
   localparam logic [7:0] AQCD_RST_GATE = 8'h00;
   localparam int AQCD_POS_SCALE_LO = 0;
   localparam int AQCD_POS_MUX_LO = 3;
   localparam int AQCD_POS_CURMON = 4;
   localparam int AQCD_POS_DIRECT = 5;
   localparam int AQCD_POS_POLARITY = 6;
   localparam int AQCD_POS_OPAMP = 7;
   localparam int AQCD_POS_TMON = 0;
   localparam int AQCD_POS_DRIVE_LO = 2;
   localparam int AQCD_POS_HIGH_DRIVE = 7;
   localparam logic [1:0] AQCD_MUX_PRESCALER = 2'h0;
   localparam logic [1:0] AQCD_MUX_DIRECT = 2'h1;
   localparam logic [1:0] AQCD_MUX_MONITOR = 2'h2;
   localparam logic [1:0] AQCD_MUX_INVALID = 2'h3;
   localparam logic [2:0] AQCD_TSCALE_16V = 3'h0;
   localparam logic [2:0] AQCD_TSCALE_4V = 3'h2;
   typedef enum logic [3:0] {
      AQCD_ADC_PRESCALER = 4'h1,
      AQCD_ADC_DIRECT = 4'h2,
      AQCD_ADC_MONITOR = 4'h4,
      AQCD_ADC_NONE = 4'h8
   } aqcd_adc_src_e;
   typedef enum logic [3:0] {
      AQCD_GATE_OFF = 4'h1,
      AQCD_GATE_LOW = 4'h2,
      AQCD_GATE_HIGH = 4'h4,
      AQCD_GATE_BAD = 4'h8
   } aqcd_gate_e;
endpackage

// [tb/aqcd_cfg_writer.sv]
/* Configuring party: writes one byte per request.
   Assumes requests sampled on the rising edge of i_clk. */
`timescale 1ns/1ps
`default_nettype none
module aqcd_cfg_writer (
   // Clock and request
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_data,
   // Configuration port
   output logic o_wr_en,
   output logic [1:0] o_addr,
   output logic [7:0] o_wdata
);
   initial {o_wr_en, o_addr, o_wdata} = 11'h000;
   // Idle bus toggles so stale values are never trusted
   always @(posedge i_clk) begin
      o_wr_en <= #1 i_req;
      o_addr <= #1 i_req ? i_addr : ~o_addr;
      o_wdata <= #1 !i_req ? ~o_wdata :
         (i_addr == 2'h3) ? (i_data & 8'hBF) : i_data;
   end
endmodule
`default_nettype wire

// [tb/aqcd_properties.sv]
/* Port checker for aqcd_top, bound below.
   Assumes one clock with sync active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module aqcd_properties (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Inputs
   input wire logic i_cfg_wr_en,
   input wire logic [1:0] i_cfg_addr,
   input wire logic [7:0] i_cfg_wdata,
   input wire logic i_gate_driver_on,
   // Outputs
   input wire logic [7:0] o_cfg_rdata,
   input wire logic [2:0] o_temperature_pad_scale,
   input wire logic [3:0] o_voltage_pad_adc_src,
   input wire logic o_current_pad_direct_sw,
   input wire logic o_temperature_pad_negative,
   input wire logic o_current_pad_opamp_on,
   input wire logic o_current_monitor_sw,
   input wire logic [1:0] o_gate_pad_current_sel,
   input wire logic o_gate_pad_negative,
   input wire logic [3:0] o_gate_pad_mode,
   input wire logic o_temp_monitor_power_ctl
);
   logic [1:0] v_reg = 2'h0;
   logic [1:0] a1_reg, a2_reg;
   logic [7:0] d1_reg, d2_reg;
   // Write taken two edges ago, per byte
   wire logic w_v = v_reg[1] && a2_reg == 2'h0;
   wire logic w_c = v_reg[1] && a2_reg == 2'h1;
   wire logic w_g = v_reg[1] && a2_reg == 2'h2;
   wire logic w_t = v_reg[1] && a2_reg == 2'h3;
   always_ff @(posedge i_clk) begin
      v_reg <= {v_reg[0] && !i_sys_rst, i_cfg_wr_en && !i_sys_rst};
      {a2_reg, a1_reg} <= {a1_reg, i_cfg_addr};
      {d2_reg, d1_reg} <= {d1_reg, i_cfg_wdata};
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   AST_ADC_ROUTE: assert property (w_v |->
      o_voltage_pad_adc_src == (4'h1 << d2_reg[4:3])) else $error("adc src");
   AST_DIRECT_SW: assert property (w_c |->
      o_current_pad_direct_sw == d2_reg[5]) else $error("direct switch");
   AST_POLARITY: assert property (w_t |->
      o_temperature_pad_negative == d2_reg[6]) else $error("polarity");
   AST_OPAMP: assert property (w_c |->
      o_current_pad_opamp_on == d2_reg[7]) else $error("op amp power");
   AST_CUR_MON: assert property (w_v |->
      o_current_monitor_sw == d2_reg[4]) else $error("monitor switch");
   AST_GATE_FIELDS: assert property (w_g |->
      {o_gate_pad_current_sel, o_gate_pad_negative,
      o_temp_monitor_power_ctl} == {d2_reg[3:2], d2_reg[6], d2_reg[0]})
      else $error("gate fields");
   AST_GATE_OFF: assert property (!i_gate_driver_on [*4] |->
      o_gate_pad_mode == 4'h1) else $error("gate not off");
   AST_SCALE: assert property (w_t |->
      o_temperature_pad_scale == d2_reg[2:0]) else $error("scale");
   AST_RESET_VAL: assert property ($fell(i_sys_rst) |->
      o_cfg_rdata == 8'h00 && o_voltage_pad_adc_src == 4'h1)
      else $error("rst");
   AST_HOLD: assert property (!v_reg[1] && !$past(i_sys_rst) |->
      $stable({o_voltage_pad_adc_src, o_gate_pad_current_sel}))
      else $error("hold");
   cover property (w_g && d2_reg[7] && i_gate_driver_on);
   cover property (w_v && d2_reg[4:3] == 2'h3);
   cover property (w_t);
endmodule
bind aqcd_top aqcd_properties i_props (.*);
`default_nettype wire

// [tb/tb_top.sv]
/* Random back-to-back byte writes, decoded lines checked.
   Assumes aqcd_top decodes two edges after a write. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic i_clk = 1'b0, i_sys_rst = 1'b1, i_gate_driver_on = 1'b0;
   logic i_cfg_wr_en, req = 1'b0;
   logic [1:0] i_cfg_addr, r_addr, o_gate_pad_current_sel, pv = 2'h0;
   logic [7:0] i_cfg_wdata, o_cfg_rdata, r_data;
   logic [2:0] o_voltage_pad_scale, o_current_pad_scale;
   logic [2:0] o_temperature_pad_scale;
   logic [3:0] o_voltage_pad_adc_src, o_current_pad_adc_src;
   logic [3:0] o_temperature_pad_adc_src, o_gate_pad_mode;
   logic o_voltage_pad_direct_sw, o_voltage_pad_negative;
   logic o_voltage_pad_opamp_on, o_current_monitor_sw;
   logic o_current_pad_direct_sw, o_current_pad_negative;
   logic o_current_pad_opamp_on, o_temperature_pad_direct_sw;
   logic o_temperature_pad_negative, o_temperature_pad_opamp_on;
   logic o_temperature_pad_cfg_err, o_gate_pad_negative;
   logic o_temp_monitor_power_ctl;
   logic [10:0] note;
   logic [10:0] q[$];
   logic [15:0] sv, ev, rv;
   logic [7:0] rd_exp, shadow [4];
   logic rd_ok = 1'h0;
   int err_count = 0, total_checks = 0, seed = 59;
   aqcd_top i_dut (.*);
   aqcd_cfg_writer i_writer (.i_clk(i_clk), .i_req(req), .i_addr(r_addr),
      .i_data(r_data), .o_wr_en(i_cfg_wr_en), .o_addr(i_cfg_addr),
      .o_wdata(i_cfg_wdata));
   function automatic logic [15:0] expv(logic [10:0] n);
      logic [7:0] b;
      b = n[7:0];
      if (n[9:8] == 2'h2)
         return {8'h00, b[6], b[3:2], b[0],
            !n[10] ? 4'h1 : b[7] ? 4'h4 : 4'h2};
      return {4'h0, b[7], b[6], b[5], n[9:8] == 2'h3 ? (b[2:0] != 3'h0 &&
         b[2:0] != 3'h2) || b[6] : n[9:8] == 2'h0 && b[4],
         4'h1 << b[4:3], 1'b0, b[2:0]};
   endfunction
   function automatic logic [15:0] obsv(logic [1:0] a);
      case (a)
         2'h0: return {4'h0, o_voltage_pad_opamp_on, o_voltage_pad_negative,
            o_voltage_pad_direct_sw, o_current_monitor_sw,
            o_voltage_pad_adc_src, 1'b0, o_voltage_pad_scale};
         2'h1: return {4'h0, o_current_pad_opamp_on, o_current_pad_negative,
            o_current_pad_direct_sw, 1'b0, o_current_pad_adc_src, 1'b0,
            o_current_pad_scale};
         2'h2: return {8'h00, o_gate_pad_negative, o_gate_pad_current_sel,
            o_temp_monitor_power_ctl, o_gate_pad_mode};
         default: return {4'h0, o_temperature_pad_opamp_on,
            o_temperature_pad_negative, o_temperature_pad_direct_sw,
            o_temperature_pad_cfg_err, o_temperature_pad_adc_src, 1'b0,
            o_temperature_pad_scale};
      endcase
   endfunction
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (err_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial forever #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      pv <= {pv[0], i_cfg_wr_en && !i_sys_rst};
      // Read data launched last edge from bytes stored before it
      if (rd_ok)
         check("read data", o_cfg_rdata, rd_exp);
      rd_ok = !i_sys_rst;
      rd_exp = shadow[i_cfg_addr];
      if (i_sys_rst)
         shadow = '{default: 8'h00};
      else if (i_cfg_wr_en)
         shadow[i_cfg_addr] = i_cfg_wdata;
      if (pv[1] && q.size() != 0) begin
         note = q.pop_front();
         sv = obsv(note[9:8]);
         ev = expv(note);
         check("low", sv[7:0], ev[7:0]);
         check("high", sv[15:8], ev[15:8]);
      end
   end
   initial begin
      repeat (3) @(posedge i_clk);
      #1 i_sys_rst = 1'b0;
      rv = {o_cfg_rdata, o_gate_pad_mode, o_voltage_pad_adc_src};
      check("reset lines", rv, 16'h0011);
      for (int k = 0; k < 90; k++) begin
         @(posedge i_clk);
         #1;
         if (k == 45)
            i_gate_driver_on = 1'b1;
         {r_data, r_addr} = 10'($random(seed));
         if (r_addr == 2'h3)
            r_data[6] = 1'b0;
         req = k % 45 >= 5 && k % 45 < 40 && k % 4 != 3;
         if (req)
            q.push_back({i_gate_driver_on, r_addr, r_data});
      end
      req = 1'b0;
      for (int t = 0; t < 10 && q.size() != 0; t++) @(posedge i_clk);
      if (q.size() != 0)
         err_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
